// file: strap_address_latch.sv
// strap sampler: turns three five-level strap codes into the own address
// assumes strap codes arrive asynchronously and stay stable after power-up
`timescale 1ns/1ps
module strap_address_latch (
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   input  wire logic       resample_i,
   input  wire logic [2:0] addr_strap_high_i,
   input  wire logic [2:0] addr_strap_mid_i,
   input  wire logic [2:0] addr_strap_low_i,
   output logic      [6:0] own_addr_o,
   output logic            addr_valid_o
);
   import ufm_pkg::*;

   logic [8:0] strap_meta;
   logic [8:0] strap_sync;
   logic [1:0] settle;
   logic [6:0] strap_sum;

   // two-stage synchroniser; meta stage feeds only the sync stage
   always_ff @(posedge clk_i) begin
      strap_meta <= {addr_strap_high_i, addr_strap_mid_i, addr_strap_low_i};
      strap_sync <= strap_meta;
   end

   assign strap_sum = ADDR_BASE
                    + 7'({4'h0, strap_sync[8:6]}) * STRAP_HIGH_WT
                    + 7'({4'h0, strap_sync[5:3]}) * STRAP_MID_WT
                    + 7'({4'h0, strap_sync[2:0]});

   // capture after reset release
   // waits for fresh synchroniser contents before taking the address
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         settle       <= STRAP_SETTLE;
         addr_valid_o <= 1'b0;
         own_addr_o   <= 7'h00;
      end else if (resample_i) begin
         settle <= STRAP_SETTLE;
      end else if (settle != 2'h0) begin
         settle <= settle - 2'h1;
         if (settle == 2'h1) begin
            own_addr_o   <= strap_sum;
            addr_valid_o <= 1'b1;
         end
      end
   end

   chk_strap_capture: assert property (
      @(posedge clk_i) disable iff (srst_i)
      (settle == 2'h1 && !resample_i) |=>
         (addr_valid_o && own_addr_o == $past(strap_sum)))
      else $error("own address not taken from straps");

   chk_strap_timing: assert property (
      @(posedge clk_i) disable iff (srst_i)
      $fell(srst_i) |-> ##2 (settle == 2'h1))
      else $error("strap capture not three cycles after reset");
endmodule

// file: testbench.sv
// self-checking bench for the write-only serial slave
// assumes one 200 MHz clock; the master model drives the link
`timescale 1ns/1ps
module testbench;
   import ufm_pkg::*;
   logic        clk = 1'b0;
   logic        srst, scl, m_low, sda_o_w, sda_oe, wr_en, sw_reset;
   logic [2:0]  st_hi, st_mid, st_lo;
   logic [6:0]  wr_addr, own_m;
   logic [7:0]  wr_data, ctrl_byte, mode_m, bc_m, ctrl_m;
   logic [7:0]  grp_m [3];
   logic [15:0] res;
   logic [15:0] exp_q [$];
   logic [6:0]  starts [4] = '{7'h3e, 7'h15, 7'h25, 7'h15};
   int          lens [4] = '{8, 6, 5, 6};
   int          err_total, checks_done, cycles;
   integer      seed;
   wire         sda_w;
   // open-drain wire with pull-up: low if either party pulls
   assign sda_w = ~(m_low | (sda_oe & ~sda_o_w));
   always #2.5 clk = ~clk;
   ufm_write_slave_addr_pointer ufm_write_slave_addr_pointer_inst (
      .clk_i(clk), .srst_i(srst), .scl_i(scl), .sda_i(sda_w),
      .sda_o(sda_o_w), .sda_oe_o(sda_oe), .addr_strap_high_i(st_hi),
      .addr_strap_mid_i(st_mid), .addr_strap_low_i(st_lo),
      .wr_en_o(wr_en), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
      .sw_reset_o(sw_reset), .ctrl_byte_o(ctrl_byte));
   ufm_master_model ufm_master_model_inst (
      .clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_low_o(m_low));
   task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // expected pointer step for a flag and select setting
   function automatic logic [6:0] next_ptr(input logic [6:0] p,
                                           input logic f, input logic [1:0] s);
      logic [6:0] lo, hi;
      lo = (s == 2'h1) ? WIN_BRIGHT_LO : (s == 2'h3) ? WIN_GROUP_LO : WIN_MAP_LO;
      hi = (s == 2'h0) ? WIN_MAP_HI : (s == 2'h2) ? WIN_GAIN_HI : WIN_BRIGHT_HI;
      if (!f) return p;
      if (p == hi) return lo;
      if (p == WIN_MAP_HI) return 7'h00;
      return p + 7'h01;
   endfunction
   task automatic model_reset();
      mode_m = MODE_RESET;
      bc_m   = BCAST_RESET;
      grp_m  = '{GROUP_RESET, GROUP_RESET, GROUP_RESET};
      ctrl_m = CTRL_RESET;
   endtask
   // one frame; address-table bytes beyond the first keep their values
   task automatic frame(input logic [6:0] a, input logic rw,
                        input logic [7:0] ctrl, input int n,
                        input logic [7:0] d0);
      logic       ack, hit, tab;
      logic [6:0] p;
      logic [7:0] d;
      hit = !rw && (a == own_m || (mode_m[0] && a == bc_m[7:1])
            || (mode_m[3] && a == grp_m[0][7:1])
            || (mode_m[2] && a == grp_m[1][7:1])
            || (mode_m[1] && a == grp_m[2][7:1]));
      ufm_master_model_inst.start_cond();
      ufm_master_model_inst.addr_byte(a, rw, ack);
      check_val({15'h0, ack}, {15'h0, hit});
      if (hit) begin
         ufm_master_model_inst.send_byte(ctrl, ack);
         check_val({15'h0, ack}, 16'h0001);
         p = ctrl[6:0];
         for (int i = 0; i < n; i++) begin
            d = (i == 0) ? d0 : 8'($random(seed));
            tab = p >= REG_GROUP_ONE && p < REG_BROADCAST;
            if (i > 0 && p == REG_FIRST_MODE) d = mode_m;
            if (i > 0 && tab) d = grp_m[p[1:0]];
            if (i > 0 && p == REG_BROADCAST) d = bc_m;
            if (p == REG_FIRST_MODE) mode_m = d;
            if (tab) grp_m[p[1:0]] = d;
            if (p == REG_BROADCAST) bc_m = d;
            if (p < REG_RESERVED_LO) exp_q.push_back({1'b0, p, d});
            ufm_master_model_inst.send_byte(d, ack);
            check_val({15'h0, ack}, 16'h0001);
            p = next_ptr(p, ctrl[7], mode_m[6:5]);
         end
         ctrl_m = {ctrl[7], p};
      end
      ufm_master_model_inst.stop_cond();
      check_val({8'h00, ctrl_byte}, {8'h00, ctrl_m});
   endtask
   task automatic soft_reset_frame();
      logic ack;
      ufm_master_model_inst.start_cond();
      ufm_master_model_inst.addr_byte(SWRST_ADDR, 1'b0, ack);
      check_val({15'h0, ack}, 16'h0001);
      exp_q.push_back(16'h8000);
      ufm_master_model_inst.send_byte(SWRST_DATA, ack);
      check_val({15'h0, ack}, 16'h0001);
      ufm_master_model_inst.stop_cond();
      model_reset();
      check_val({8'h00, ctrl_byte}, {8'h00, CTRL_RESET});
   endtask
   // result watcher; also cuts a hang short
   always @(posedge clk) begin
      cycles++;
      if (cycles > 90000) begin
         err_total++;
         end_of_test();
      end
      if (wr_en === 1'b1 || sw_reset === 1'b1) begin
         res = sw_reset ? 16'h8000 : {1'b0, wr_addr, wr_data};
         if (exp_q.size() == 0) check_val(res, 16'hffff);
         else check_val(res, exp_q.pop_front());
      end
   end
   initial begin
      seed = 32'h91fd3464;
      err_total = 0;
      checks_done = 0;
      cycles = 0;
      srst = 1'b1;
      // own address 4fh avoids reserved ranges
      st_hi = STRAP_PULLED_UP;
      st_mid = STRAP_GROUND;
      st_lo = STRAP_PULLED_UP;
      own_m = 7'h4f;
      model_reset();
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      repeat (12) @(posedge clk);
      check_val({8'h00, ctrl_byte}, {8'h00, CTRL_RESET});
      frame(own_m, 1'b0, 8'h08, 3, 8'h5a);
      // select bits only ever used with the flag set
      for (int k = 0; k < 4; k++) begin
         frame(own_m, 1'b0, 8'h80, 1, {1'b0, 2'(k), 5'h09});
         frame(own_m, 1'b0, {1'b1, starts[k]}, lens[k], 8'h3c);
      end
      frame(own_m, 1'b0, 8'hfe, 4, 8'h11);
      frame(7'h70, 1'b0, 8'h88, 2, 8'ha1);
      frame(7'h76, 1'b0, 8'h8a, 1, 8'hb2);
      // group two reused while disabled, then enabled and answered
      frame(own_m, 1'b0, 8'hc1, 1, 8'h50);
      frame(7'h28, 1'b0, 8'h88, 1, 8'h01);
      frame(own_m, 1'b0, 8'h80, 1, 8'h6d);
      frame(7'h28, 1'b0, 8'h88, 1, 8'h02);
      st_hi <= STRAP_SUPPLY;
      st_mid <= STRAP_SUPPLY;
      st_lo <= STRAP_SUPPLY;
      soft_reset_frame();
      own_m = 7'h7d;
      frame(7'h4f, 1'b0, 8'h80, 1, 8'h01);
      frame(own_m, 1'b0, 8'h80, 2, MODE_RESET);
      frame(own_m, 1'b1, 8'h80, 1, 8'h01);
      frame(7'h22, 1'b0, 8'h80, 1, 8'h01);
      check_val(16'(exp_q.size()), 16'h0000);
      end_of_test();
   end
endmodule

// file: ufm_master_model.sv
// serial bus master model: clocks the link and pulls the data wire low
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps
module ufm_master_model (
   input  wire logic clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_low_o
);
   // link idles high and stands still between frames
   initial begin
      scl_o     = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // one bit, 25 clocks; data moves mid-low, sampled mid-high
   task automatic put_bit(input logic b, output logic seen);
      @(posedge clk_i) scl_o <= 1'b0;
      tick(6);
      sda_low_o <= ~b;
      tick(6);
      scl_o <= 1'b1;
      tick(6);
      seen = sda_i;
      tick(6);
   endtask
   // msb first, then data released for the ninth clock
   task automatic send_byte(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) put_bit(v[i], s);
      put_bit(1'b1, s);
      ack = ~s;
   endtask
   task automatic addr_byte(input logic [6:0] a, input logic rw,
                            output logic ack);
      send_byte({a, rw}, ack);
   endtask
   // start: data falls while the clock is high
   task automatic start_cond();
      @(posedge clk_i) sda_low_o <= 1'b1;
      tick(12);
   endtask
   // stop: data rises while the clock is high
   task automatic stop_cond();
      @(posedge clk_i) scl_o <= 1'b0;
      tick(6);
      sda_low_o <= 1'b1;
      tick(6);
      scl_o <= 1'b1;
      tick(6);
      sda_low_o <= 1'b0;
      tick(12);
   endtask
endmodule

// file: ufm_pkg.sv
// constants, state codes and layouts for the write-only serial slave
// assumes a single 200 MHz clock domain and a synchronous high reset
// How it works
// - straps are sampled after reset and soft reset into the own address
// - only the strap-derived address out of 125 is answered as own address
// - own address is one plus base-five strap value, high strap weighs most
// - only write direction accepted; no read path exists
// - broadcast address defaults to e0h, enabled after reset, volatile
// - every such device answers broadcast; master never uses it as own
// - three group addresses default to ech; only the first enabled
// - first byte after any matching address lands in the control byte
// - control byte: bits 6..0 pointer, bit 7 increment flag, reset 80h
// - byte after the soft-reset address is not a control byte
// - window chosen by flag plus mode bits 6 and 5, both reset zero
// - flag set advances pointer after every data byte written
// - setting 000b keeps pointer fixed, same register overwritten
// - setting 100b walks whole map, wraps 43h to 00h
// - setting 101b cycles brightness registers, wraps 17h to 08h
// - setting 110b cycles mode to gain registers, wraps 27h to 00h
// - setting 111b cycles group and brightness, wraps 17h to 06h
// - increment touches only pointer bits; flag bit keeps its value
// - start outside window counts up, wraps 43h to 00h, joins at end
// - bytes for unused registers are dropped, pointer still advances
// - writes to pointer range 46h..7fh are ignored entirely
package ufm_pkg;
   localparam logic [7:0] CTRL_RESET       = 8'h80;
   localparam int         CTRL_FLAG_BIT    = 7;
   localparam logic [6:0] REG_FIRST_MODE   = 7'h00;
   localparam logic [6:0] REG_GROUP_ONE    = 7'h40;
   localparam logic [6:0] REG_BROADCAST    = 7'h43;
   localparam logic [6:0] REG_RESERVED_LO  = 7'h46;
   localparam logic [6:0] WIN_MAP_LO       = 7'h00;
   localparam logic [6:0] WIN_MAP_HI       = 7'h43;
   localparam logic [6:0] WIN_BRIGHT_LO    = 7'h08;
   localparam logic [6:0] WIN_BRIGHT_HI    = 7'h17;
   localparam logic [6:0] WIN_GAIN_HI      = 7'h27;
   localparam logic [6:0] WIN_GROUP_LO     = 7'h06;
   localparam int         INCR_SELECT_HI   = 6;
   localparam int         INCR_SELECT_LO   = 5;
   localparam int         GROUP_ONE_EN_BIT = 3;
   localparam int         BCAST_EN_BIT     = 0;
   localparam int         GROUP_COUNT      = 3;
   localparam logic [7:0] MODE_RESET       = 8'h09;
   localparam logic [7:0] BCAST_RESET      = 8'he0;
   localparam logic [7:0] GROUP_RESET      = 8'hec;
   localparam logic [6:0] SWRST_ADDR       = 7'h03;
   localparam logic [7:0] SWRST_DATA       = 8'ha5;
   localparam logic [2:0] STRAP_GROUND      = 3'h0;
   localparam logic [2:0] STRAP_PULLED_DOWN = 3'h1;
   localparam logic [2:0] STRAP_FLOATING    = 3'h2;
   localparam logic [2:0] STRAP_PULLED_UP   = 3'h3;
   localparam logic [2:0] STRAP_SUPPLY      = 3'h4;
   localparam logic [6:0] ADDR_BASE        = 7'h01;
   localparam logic [6:0] STRAP_HIGH_WT    = 7'h19;
   localparam logic [6:0] STRAP_MID_WT     = 7'h05;
   localparam logic [1:0] STRAP_SETTLE     = 2'h3;
   localparam logic [3:0] BYTE_BITS        = 4'h8;
   localparam logic [3:0] LAST_BIT         = 4'h7;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_ADDR = 5'b00010,
      ST_CTRL = 5'b00100,
      ST_DATA = 5'b01000,
      ST_SWR  = 5'b10000
   } slave_state_e;
endpackage

// file: ufm_write_slave_addr_pointer.sv
// write-only serial slave: address match, control byte, pointer stepping
// assumes scl and sda come from pins and are sampled by the 200 MHz clock;
// the bus clock (125 ns bench period) gives 25 samples per bit
`timescale 1ns/1ps
module ufm_write_slave_addr_pointer (
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   input  wire logic [2:0] addr_strap_high_i,
   input  wire logic [2:0] addr_strap_mid_i,
   input  wire logic [2:0] addr_strap_low_i,
   output logic            wr_en_o,
   output logic      [6:0] wr_addr_o,
   output logic      [7:0] wr_data_o,
   output logic            sw_reset_o,
   output logic      [7:0] ctrl_byte_o
);
   import ufm_pkg::*;

   logic                   scl_meta;
   logic                   scl_sync;
   logic                   scl_prev;
   logic                   sda_meta;
   logic                   sda_sync;
   logic                   sda_prev;
   logic                   scl_rise;
   logic                   scl_fall;
   logic                   start_seen;
   logic                   stop_seen;
   logic [6:0]             shreg;
   logic [7:0]             full_byte;
   logic [3:0]             bit_cnt;
   logic                   ninth;
   logic                   byte_done;
   logic                   ack_pend;
   logic                   next_ack;
   slave_state_e           state;
   slave_state_e           next_state;
   logic [7:0]             ctrl;
   logic [7:0]             mode;
   logic [7:0]             bcast;
   logic [7:0]             group_addr [GROUP_COUNT];
   logic [GROUP_COUNT-1:0] hit_grp;
   logic [6:0]             own_addr;
   logic                   addr_valid;
   logic                   hit_own;
   logic                   hit_bcast;
   logic                   is_write;
   logic                   addr_ack;
   logic                   swr_ack;
   logic                   swr_hit;
   logic                   data_byte;
   logic                   wr_ok;
   logic                   clr;
   logic [6:0]             ptr;
   logic [1:0]             incr_sel;
   logic [6:0]             next_ptr;

   // an address register matches on its upper seven bits only
   function automatic logic addr_match(input logic [7:0] b,
                                       input logic [7:0] a);
      return b[7:1] == a[7:1];
   endfunction

   // climb, wrap at map end, join window at its end
   function automatic logic [6:0] step_pointer(input logic [6:0] p,
                                               input logic       f,
                                               input logic [1:0] s);
      logic [6:0] lo;
      logic [6:0] hi;
      lo = WIN_MAP_LO;
      hi = WIN_MAP_HI;
      case (s)
         2'b01: begin
            lo = WIN_BRIGHT_LO;
            hi = WIN_BRIGHT_HI;
         end
         2'b10: begin
            lo = WIN_MAP_LO;
            hi = WIN_GAIN_HI;
         end
         2'b11: begin
            lo = WIN_GROUP_LO;
            hi = WIN_BRIGHT_HI;
         end
         default: begin
            lo = WIN_MAP_LO;
            hi = WIN_MAP_HI;
         end
      endcase
      if (!f)
         return p;
      else if (p == hi)
         return lo;
      else if (p == WIN_MAP_HI)
         return WIN_MAP_LO;
      else
         return p + 7'h01;
   endfunction

   strap_address_latch u_strap (
      .clk_i             (clk_i),
      .srst_i            (srst_i),
      .resample_i        (sw_reset_o),
      .addr_strap_high_i (addr_strap_high_i),
      .addr_strap_mid_i  (addr_strap_mid_i),
      .addr_strap_low_i  (addr_strap_low_i),
      .own_addr_o        (own_addr),
      .addr_valid_o      (addr_valid)
   );

   // pins cross into the clock domain through two flops each
   always_ff @(posedge clk_i) begin
      scl_meta <= scl_i;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= sda_i;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
   end

   // bus events; start and stop need scl high on both samples
   assign scl_rise   = scl_sync & ~scl_prev;
   assign scl_fall   = ~scl_sync & scl_prev;
   assign start_seen = scl_sync & scl_prev & sda_prev & ~sda_sync;
   assign stop_seen  = scl_sync & scl_prev & ~sda_prev & sda_sync;
   assign full_byte  = {shreg, sda_sync};
   assign byte_done  = scl_rise & (bit_cnt == LAST_BIT);

   // decoding of the address byte
   assign is_write  = ~full_byte[0];
   assign hit_own   = addr_valid & (full_byte[7:1] == own_addr);
   assign hit_bcast = mode[BCAST_EN_BIT] & addr_match(full_byte, bcast);
   assign addr_ack  = is_write & (hit_own | hit_bcast | (|hit_grp));
   assign swr_ack   = is_write & (full_byte[7:1] == SWRST_ADDR);
   assign swr_hit   = byte_done & (state == ST_SWR)
                    & (full_byte == SWRST_DATA);

   // pointer and window selection
   assign ptr       = ctrl[6:0];
   assign incr_sel  = {mode[INCR_SELECT_HI], mode[INCR_SELECT_LO]};
   assign next_ptr  = step_pointer(ptr, ctrl[CTRL_FLAG_BIT], incr_sel);
   assign data_byte = byte_done & (state == ST_DATA);
   assign wr_ok     = data_byte & (ptr < REG_RESERVED_LO);
   assign clr       = srst_i | sw_reset_o;

   // byte sequencing and acknowledge decision
   always_comb begin
      next_state = state;
      next_ack   = 1'b0;
      if (byte_done) begin
         case (state)
            ST_ADDR: begin
               // ack only a matching write address
               if (addr_ack) begin
                  next_state = ST_CTRL;
                  next_ack   = 1'b1;
               end else if (swr_ack) begin
                  next_state = ST_SWR;
                  next_ack   = 1'b1;
               end else begin
                  next_state = ST_IDLE;
               end
            end
            ST_CTRL: begin
               next_state = ST_DATA;
               next_ack   = 1'b1;
            end
            ST_DATA: begin
               next_ack = 1'b1;
            end
            ST_SWR: begin
               next_state = ST_IDLE;
               next_ack   = swr_hit;
            end
            ST_IDLE: begin
               next_state = ST_IDLE;
            end
            default: begin
               next_state = ST_IDLE;
            end
         endcase
      end
   end

   // bit shifter; only the eight data clocks load it
   always_ff @(posedge clk_i) begin
      if (srst_i)
         shreg <= 7'h00;
      else if (scl_rise && bit_cnt != BYTE_BITS)
         shreg <= full_byte[6:0];
   end

   // frame control: start restarts the byte count, stop parks the slave;
   // the ack is driven from the eighth fall to the ninth fall
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state    <= ST_IDLE;
         bit_cnt  <= 4'h0;
         ninth    <= 1'b0;
         ack_pend <= 1'b0;
         sda_oe_o <= 1'b0;
      end else if (start_seen || stop_seen) begin
         state    <= start_seen ? ST_ADDR : ST_IDLE;
         bit_cnt  <= 4'h0;
         ninth    <= 1'b0;
         ack_pend <= 1'b0;
         sda_oe_o <= 1'b0;
      end else begin
         state <= next_state;
         if (scl_rise && bit_cnt != BYTE_BITS)
            bit_cnt <= bit_cnt + 4'h1;
         if (scl_rise && bit_cnt == BYTE_BITS)
            ninth <= 1'b1;
         if (byte_done)
            ack_pend <= next_ack;
         if (scl_fall && bit_cnt == BYTE_BITS) begin
            if (ninth) begin
               sda_oe_o <= 1'b0;
               bit_cnt  <= 4'h0;
               ninth    <= 1'b0;
            end else begin
               sda_oe_o <= ack_pend;
            end
         end
      end
   end

   // open-drain: only ever pulls low, the enable does the work
   always_ff @(posedge clk_i) begin
      sda_o <= 1'b0;
   end

   // control byte load and pointer step
   // a soft reset clears it two cycles after the reset byte
   always_ff @(posedge clk_i) begin
      if (clr)
         ctrl <= CTRL_RESET;
      else if (byte_done && state == ST_CTRL)
         ctrl <= full_byte;
      else if (data_byte)
         ctrl[6:0] <= next_ptr;
   end

   // mode copy holds select and enable bits
   always_ff @(posedge clk_i) begin
      if (clr)
         mode <= MODE_RESET;
      else if (wr_ok && ptr == REG_FIRST_MODE)
         mode <= full_byte;
   end

   always_ff @(posedge clk_i) begin
      if (clr)
         bcast <= BCAST_RESET;
      else if (wr_ok && ptr == REG_BROADCAST)
         bcast <= full_byte;
   end

   // three group addresses, enables from mode bits 3..1
   genvar g;
   generate
      for (g = 0; g < GROUP_COUNT; g++) begin : g_group
         always_ff @(posedge clk_i) begin
            if (clr)
               group_addr[g] <= GROUP_RESET;
            else if (wr_ok && ptr == REG_GROUP_ONE + 7'(g))
               group_addr[g] <= full_byte;
         end
         assign hit_grp[g] = mode[GROUP_ONE_EN_BIT - g]
                           & addr_match(full_byte, group_addr[g]);
      end
   endgenerate

   // register write strobe; unused targets just see no strobe
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wr_en_o    <= 1'b0;
         wr_addr_o  <= 7'h00;
         wr_data_o  <= 8'h00;
         sw_reset_o <= 1'b0;
      end else begin
         wr_en_o    <= wr_ok;
         sw_reset_o <= swr_hit;
         if (wr_ok) begin
            wr_addr_o <= ptr;
            wr_data_o <= full_byte;
         end
      end
   end

   assign ctrl_byte_o = ctrl;

   chk_ctrl_reset: assert property (
      @(posedge clk_i) disable iff (srst_i)
      $fell(srst_i) |-> (ctrl == CTRL_RESET && mode == MODE_RESET))
      else $error("control or mode not at reset value");

   chk_first_byte: assert property (
      @(posedge clk_i) disable iff (srst_i)
      (byte_done && state == ST_CTRL) |=>
         (ctrl == $past(full_byte) && !wr_en_o && state == ST_DATA))
      else $error("first byte not taken as control byte");

   chk_ptr_fixed: assert property (
      @(posedge clk_i) disable iff (srst_i)
      (data_byte && !ctrl[CTRL_FLAG_BIT] && incr_sel == 2'b00) |=>
         (ptr == $past(ptr)))
      else $error("pointer moved without increment");

   chk_wrap_map: assert property (
      @(posedge clk_i) disable iff (srst_i)
      (data_byte && ctrl[CTRL_FLAG_BIT] && incr_sel == 2'b00
       && ptr == 7'h43) |=> (ptr == 7'h00))
      else $error("full map wrap wrong");

   chk_wrap_bright: assert property (
      @(posedge clk_i) disable iff (srst_i)
      (data_byte && ctrl[CTRL_FLAG_BIT] && incr_sel == 2'b01
       && ptr == 7'h17) |=> (ptr == 7'h08))
      else $error("brightness wrap wrong");

   chk_wrap_gain: assert property (
      @(posedge clk_i) disable iff (srst_i)
      (data_byte && ctrl[CTRL_FLAG_BIT] && incr_sel == 2'b10
       && ptr == 7'h27) |=> (ptr == 7'h00))
      else $error("gain window wrap wrong");

   chk_wrap_group: assert property (
      @(posedge clk_i) disable iff (srst_i)
      (data_byte && ctrl[CTRL_FLAG_BIT] && incr_sel == 2'b11
       && ptr == 7'h17) |=> (ptr == 7'h06))
      else $error("group window wrap wrong");

   chk_outside_wrap: assert property (
      @(posedge clk_i) disable iff (srst_i)
      (data_byte && ctrl[CTRL_FLAG_BIT] && incr_sel == 2'b01
       && ptr == 7'h43) |=> (ptr == 7'h00))
      else $error("outside start did not wrap to zero");

   chk_step_flag_kept: assert property (
      @(posedge clk_i) disable iff (srst_i)
      (data_byte && ctrl[CTRL_FLAG_BIT] && ptr == 7'h10) |=>
         (ctrl[CTRL_FLAG_BIT] && ptr == 7'h11))
      else $error("step changed flag or missed increment");

   chk_write_strobe: assert property (
      @(posedge clk_i) disable iff (srst_i)
      (data_byte && ptr < REG_RESERVED_LO) |=>
         (wr_en_o && wr_addr_o == $past(ptr)
          && wr_data_o == $past(full_byte)) ##1 !wr_en_o)
      else $error("data write strobe wrong");

   chk_reserved_drop: assert property (
      @(posedge clk_i) disable iff (srst_i)
      (data_byte && ptr >= REG_RESERVED_LO) |=>
         (!wr_en_o && $stable(mode) && $stable(bcast)))
      else $error("reserved pointer write took effect");

   chk_read_refused: assert property (
      @(posedge clk_i) disable iff (srst_i)
      (byte_done && state == ST_ADDR && full_byte[0]) |=>
         (!ack_pend && state == ST_IDLE))
      else $error("read request acknowledged");

   chk_bcast_answer: assert property (
      @(posedge clk_i) disable iff (srst_i)
      (byte_done && state == ST_ADDR && is_write && hit_bcast) |=>
         (ack_pend && state == ST_CTRL))
      else $error("broadcast address not answered");

   chk_ack_drive: assert property (
      @(posedge clk_i) disable iff (srst_i)
      (scl_fall && bit_cnt == BYTE_BITS && !ninth) |=>
         (sda_oe_o == $past(ack_pend)))
      else $error("ack drive does not follow decision");

   chk_swrst_bypass: assert property (
      @(posedge clk_i) disable iff (srst_i)
      swr_hit |=> (sw_reset_o && $stable(ctrl)) ##1 (ctrl == CTRL_RESET))
      else $error("soft reset byte touched control byte");
endmodule
